// ---- rtl/fixu_consts.svh ----
// Offsets, field positions, reset values and timing counts of the truncating converter
`ifndef FIXU_CONSTS_SVH
`define FIXU_CONSTS_SVH

// ---------------------------------------------------------------
// Operation codes and timing
// ---------------------------------------------------------------
`define OPC_TRUNC        8'h7d
`define OPC_TRUNC_FLAGS  8'h7e
`define OP_LATENCY       3

// ---------------------------------------------------------------
// Exception flag vector layout
// ---------------------------------------------------------------
`define FLAG_W           8
`define FLAG_INEXACT     1
`define FLAG_INVALID     4
`define FLAG_FLUSH_ZERO  5
`define FLAG_MASK        8'h3f

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ADDR_W           8
`define OFF_PSW          8'h00
`define OFF_DEST         8'h04
`define OFF_INT_STATUS   8'h08
`define OFF_INT_MASK     8'h0c
`define OFF_STATE        8'h10

// ---------------------------------------------------------------
// Interrupt bits and reset values
// ---------------------------------------------------------------
`define INT_W            2
`define INT_DONE         0
`define INT_INVALID      1
`define PSW_RESET        8'h00
`define INT_MASK_RESET   2'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- rtl/fixu_pkg.sv ----
// Types shared by the truncating float to unsigned converter
`default_nettype none

package fixu_pkg;
  `include "fixu_consts.svh"

  typedef enum logic [1:0] {
    OP_NONE,
    OP_CONVERT,
    OP_FLAGS
  } op_kind_t;

  typedef struct packed {
    logic [31:0]          value;
    logic [`FLAG_W-1:0]   flags;
  } conv_t;
endpackage

`default_nettype wire

// ---- rtl/float_to_uint_truncate_unit.sv ----
// Float to unsigned truncating conversion unit with flag-only variant and AXI4-Lite status registers
`default_nettype none
`include "fixu_consts.svh"

// Contract
// RULE1 - Convert float to unsigned, truncate, ignore rounding
// RULE2 - Opcode 125, one operand, latency three
// RULE3 - Denormal input becomes zero, sets flush flag
// RULE4 - Conversion exceptions set status word flags
// RULE5 - Flags sticky; only explicit status write clears
// RULE6 - Flags update in same cycle as result
// RULE7 - Simultaneous updates OR into existing flags
// RULE8 - False guard suppresses result and flag writes
// RULE9 - Opcode 126 writes flag vector, latency three
// RULE10 - Flag vector matches status word bit layout
// RULE11 - Flags-only operation leaves status word untouched
// RULE12 - Denormal in flags op yields 0x20
// RULE13 - Nonzero fraction truncates, raises inexact 0x02
// RULE14 - Positive infinity saturates, raises invalid
// RULE15 - Negative source gives zero, raises invalid; code raises invalid only for magnitudes of one or more, including infinity
// RULE16 - NaN source gives zero, raises invalid
// RULE17 - Invalid occupies 0x10 in flag vector
// RULE18 - False guard leaves flags op destination unchanged
// RULE19 - Operands are 32-bit words, IEEE single in
module float_to_uint_truncate_unit
  import fixu_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Issue from the instruction pipeline
  input  wire logic                 issue_valid,
  input  wire logic [7:0]           issue_opcode,
  input  wire logic [31:0]          issue_source,
  input  wire logic                 issue_guard_present,
  input  wire logic [31:0]          issue_guard,
  // Flags raised by other floating-point units in this cycle
  input  wire logic [`FLAG_W-1:0]   other_fp_flags,
  // Destination write-back
  output logic                      dest_write,
  output logic [31:0]               dest_data,
  output logic [`FLAG_W-1:0]        program_status_word,
  output logic                      irq,
  // AXI4-Lite slave
  input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  localparam int STAGES = `OP_LATENCY;
  // ---------------------------------------------------------------
  // Conversion core
  // ---------------------------------------------------------------
  function automatic conv_t convert(input logic [31:0] src);
    logic        sign;
    logic [7:0]  expo;
    logic [22:0] frac;
    logic [55:0] shifted;
    logic [4:0]  shamt;
    conv_t       r;
    sign    = src[31];
    expo    = src[30:23];
    frac    = src[22:0];
    shamt   = 5'h00;
    shifted = 56'h0;
    r.value = 32'h0;
    r.flags = '0;
    if (expo == 8'h00)
    begin
      // Denormal treated as zero
      if (frac != 23'h0)
        r.flags[`FLAG_FLUSH_ZERO] = 1'b1; // RULE3 RULE12
    end
    else if (expo == 8'hff)
    begin
      r.flags[`FLAG_INVALID] = 1'b1; // RULE16 RULE17
      if (frac == 23'h0 && !sign)
        r.value = 32'hffffffff; // RULE14
    end
    else if (expo < 8'h7f)
      r.flags[`FLAG_INEXACT] = 1'b1; // RULE13
    else if (sign)
      r.flags[`FLAG_INVALID] = 1'b1; // RULE15
    else if (expo >= 8'h9f)
    begin
      r.value                = 32'hffffffff;
      r.flags[`FLAG_INVALID] = 1'b1;
    end
    else
    begin
      // Rounding mode is never consulted: plain truncation
      shamt   = 5'(expo - 8'h7f);
      shifted = {32'h0, 1'b1, frac} << shamt; // RULE1 RULE19
      r.value = shifted[54:23];
      if (shifted[22:0] != 23'h0)
        r.flags[`FLAG_INEXACT] = 1'b1; // RULE13
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Issue decode
  // ---------------------------------------------------------------
  conv_t    issue_conv;
  op_kind_t issue_kind;
  logic     guard_ok;
  logic     [31:0] issue_data;

  always_comb
  begin
    issue_conv = convert(issue_source);
    guard_ok   = !issue_guard_present || issue_guard[0]; // RULE8 RULE18
    issue_kind = OP_NONE;
    if (issue_valid && guard_ok)
    begin
      if (issue_opcode == `OPC_TRUNC)
        issue_kind = OP_CONVERT; // RULE2
      else if (issue_opcode == `OPC_TRUNC_FLAGS)
        issue_kind = OP_FLAGS; // RULE9
    end
    if (issue_kind == OP_FLAGS)
      issue_data = {{(32-`FLAG_W){1'b0}}, issue_conv.flags}; // RULE10
    else
      issue_data = issue_conv.value;
  end

  // ---------------------------------------------------------------
  // Three-stage result pipeline
  // ---------------------------------------------------------------
  op_kind_t           stage_op_reg    [STAGES];
  logic [31:0]        stage_data_reg  [STAGES];
  logic [`FLAG_W-1:0] stage_flags_reg [STAGES];
  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : g_stage
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          stage_op_reg[g]    <= OP_NONE;
          stage_data_reg[g]  <= 32'h0;
          stage_flags_reg[g] <= '0;
        end
        else
        begin
          stage_op_reg[g]    <= (g == 0) ? issue_kind : stage_op_reg[(g == 0) ? 0 : g - 1];
          stage_data_reg[g]  <= (g == 0) ? issue_data : stage_data_reg[(g == 0) ? 0 : g - 1];
          stage_flags_reg[g] <= (g == 0) ? issue_conv.flags : stage_flags_reg[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate
  // Result leaves the last stage three cycles after issue
  assign dest_write = (stage_op_reg[STAGES-1] != OP_NONE); // RULE2 RULE9
  assign dest_data  = stage_data_reg[STAGES-1];
  // Stage feeding the write-back edge
  logic               wb_next;
  logic [`FLAG_W-1:0] conv_set;
  always_comb
  begin
    wb_next  = (stage_op_reg[STAGES-2] != OP_NONE);
    // Flags-only operation contributes nothing to the status word
    if (stage_op_reg[STAGES-2] == OP_CONVERT)
      conv_set = stage_flags_reg[STAGES-2]; // RULE4 RULE11
    else
      conv_set = '0;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic               aw_held_reg;
  logic               w_held_reg;
  logic [`ADDR_W-1:0] aw_addr_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               awready_reg;
  logic               wready_reg;
  logic               wr_fire;
  logic               wr_hit;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit  = (aw_addr_reg == `OFF_PSW) || (aw_addr_reg == `OFF_INT_MASK) || (aw_addr_reg == `OFF_DEST)
                || (aw_addr_reg == `OFF_INT_STATUS) || (aw_addr_reg == `OFF_STATE);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      awready_reg <= 1'b1;
    end
    else if (s_axi_awvalid && awready_reg)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
      awready_reg <= 1'b0;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      wready_reg <= 1'b1;
    end
    else if (s_axi_wvalid && wready_reg)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
      wready_reg <= 1'b0;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Byte lane 0 carries every writable field
  logic psw_wr;
  logic mask_wr;
  assign psw_wr  = wr_fire && (aw_addr_reg == `OFF_PSW) && w_strb_reg[0];
  assign mask_wr = wr_fire && (aw_addr_reg == `OFF_INT_MASK) && w_strb_reg[0];

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        arready_reg;
  logic        rd_fire;
  logic        status_rd;
  logic [31:0] rd_value;
  logic        rd_hit;

  assign rd_fire   = s_axi_arvalid && arready_reg;
  assign status_rd = rd_fire && (s_axi_araddr == `OFF_INT_STATUS);

  // ---------------------------------------------------------------
  // Status word, destination copy, interrupts
  // ---------------------------------------------------------------
  logic [`FLAG_W-1:0] psw_reg;
  logic [31:0]        dest_last_reg;
  logic [`INT_W-1:0]  int_status_reg;
  logic [`INT_W-1:0]  int_mask_reg;
  logic               irq_reg;
  logic [`INT_W-1:0]  int_set;
  logic [`FLAG_W-1:0] psw_base;

  always_comb
  begin
    // Explicit write replaces, then this cycle's raises still land
    psw_base = psw_wr ? (w_data_reg[`FLAG_W-1:0] & `FLAG_MASK) : psw_reg; // RULE5
    int_set  = '0;
    int_set[`INT_DONE]    = wb_next;
    int_set[`INT_INVALID] = conv_set[`FLAG_INVALID];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      psw_reg <= `PSW_RESET;
    else
      psw_reg <= psw_base | ((conv_set | other_fp_flags) & `FLAG_MASK); // RULE5 RULE6 RULE7
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      dest_last_reg <= 32'h0;
    else if (wb_next)
      dest_last_reg <= stage_data_reg[STAGES-2];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      int_status_reg <= '0;
    else if (status_rd)
      int_status_reg <= int_set;
    else
      int_status_reg <= int_status_reg | int_set;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      int_mask_reg <= `INT_MASK_RESET;
    else if (mask_wr)
      int_mask_reg <= w_data_reg[`INT_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(int_status_reg & int_mask_reg);
  end

  assign program_status_word = psw_reg;
  assign irq                 = irq_reg;

  // ---------------------------------------------------------------
  // Read data mux and response
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_hit   = 1'b1;
    rd_value = 32'h0;
    case (s_axi_araddr)
      `OFF_PSW:        rd_value = {{(32-`FLAG_W){1'b0}}, psw_reg};
      `OFF_DEST:       rd_value = dest_last_reg;
      `OFF_INT_STATUS: rd_value = {{(32-`INT_W){1'b0}}, int_status_reg};
      `OFF_INT_MASK:   rd_value = {{(32-`INT_W){1'b0}}, int_mask_reg};
      `OFF_STATE:      rd_value = {29'h0, stage_op_reg[2] != OP_NONE,
                                   stage_op_reg[1] != OP_NONE, stage_op_reg[0] != OP_NONE};
      default:         rd_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `RESP_OKAY;
      arready_reg <= 1'b1;
    end
    else if (rd_fire)
    begin
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_value;
      rresp_reg   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      arready_reg <= 1'b0;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

endmodule

`default_nettype wire

// ---- verification/fixu_props.sv ----
// Concurrent properties on the converter's ports
`default_nettype none
`include "fixu_consts.svh"

module fixu_props
  import fixu_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               issue_valid,
  input wire logic [7:0]         issue_opcode,
  input wire logic               issue_guard_present,
  input wire logic [31:0]        issue_guard,
  input wire logic [`FLAG_W-1:0] other_fp_flags,
  input wire logic               dest_write,
  input wire logic [`FLAG_W-1:0] program_status_word,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata
);
  logic take;

  assign take = issue_valid && (issue_opcode == `OPC_TRUNC || issue_opcode == `OPC_TRUNC_FLAGS)
                && (!issue_guard_present || issue_guard[0]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // Steps
  // ---------------------------------------------------------------
  sequence s_taken;
    take;
  endsequence
  sequence s_result;
    ##3 dest_write;
  endsequence
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_result_latency:
    assert property (s_taken |-> s_result) else $error("result missing after issue");
  a_no_stray_write:
    assert property (dest_write |-> $past(take, 3)) else $error("write without issue");
  a_guard_blocks:
    assert property (issue_valid && issue_guard_present && !issue_guard[0] |-> ##3 !dest_write)
      else $error("false guard wrote");
  a_flags_sticky:
    assert property (!$past(reset) && |($past(program_status_word) & ~program_status_word)
      |-> $rose(s_axi_bvalid)) else $error("flag cleared without write");
  a_flags_or_in:
    assert property (!$past(reset) |-> ((program_status_word & $past(other_fp_flags) & `FLAG_MASK)
      == ($past(other_fp_flags) & `FLAG_MASK))) else $error("other flags lost");
  a_flags_with_result:
    assert property (!$past(reset) && |(program_status_word & ~$past(program_status_word)
      & ~$past(other_fp_flags)) |-> dest_write || $rose(s_axi_bvalid)) else $error("flag set off result");
  a_write_answer:
    assert property (s_write_taken |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("no read response");
  a_read_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule

`default_nettype wire

// ---- verification/fixu_regfile_model.sv ----
// Destination register of the issuing pipeline
`default_nettype none

module fixu_regfile_model
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        dest_write,
  input  wire logic [31:0] dest_data,
  output var  logic [31:0] dest_value
);
  timeunit 1ns;
  timeprecision 1ns;

  // Keeps its value unless a result arrives
  always_ff @(posedge clk)
  begin
    if (reset)
      dest_value <= 32'h0;
    else if (dest_write)
      dest_value <= dest_data;
  end
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench of the truncating converter
`default_nettype none
`include "fixu_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, issue_valid = 0, issue_guard_present = 0, dest_write, irq;
  logic [7:0]  issue_opcode = 0, other_fp_flags = 0, program_status_word, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] issue_source = 0, issue_guard = 0, dest_data, dest_value, s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ist_m, mask_m;
  int          fail_count = 0, checks = 0, i, k;
  logic [31:0] seed = 32'h05f7, rd_exp, last_m, od, wd;
  logic [39:0] r1, r2;
  logic [7:0]  psw_m, wa;
  logic        v1, v2, c1, c2, ov, wr_pend;
  logic [31:0] vec [12] = '{32'h40400000, 32'h40247ae1, 32'hff4fffff, 32'h7f800000, 32'hbfc147ae,
    32'h00400000, 32'h7fc00000, 32'hffbfffff, 32'h4f800000, 32'h3f000000, 32'hbf000000, 32'h0};

  always #50 clk = ~clk;

  float_to_uint_truncate_unit dut_u (.clk, .reset, .issue_valid, .issue_opcode, .issue_source,
    .issue_guard_present, .issue_guard, .other_fp_flags, .dest_write, .dest_data, .program_status_word,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fixu_regfile_model regfile_u (.clk, .reset, .dest_write, .dest_data, .dest_value);

  // ---------------------------------------------------------------
  // Reference conversion: {result, flag vector}
  // ---------------------------------------------------------------
  function automatic logic [39:0] conv(input logic [31:0] f);
    logic [55:0] m;
    int          e;
    m = {32'h0, 1'b1, f[22:0]};
    e = f[30:23];
    if (e == 0) return {32'h0, (f[22:0] != 0) ? 8'h20 : 8'h00};
    if (e == 255 && (f[22:0] != 0 || f[31])) return {32'h0, 8'h10};
    if (f[31]) return {32'h0, (e >= 127) ? 8'h10 : 8'h02};
    if (e >= 159) return {32'hffffffff, 8'h10};
    if (e < 127) return {32'h0, 8'h02};
    m = m << (e - 127);
    return {m[54:23], (m[22:0] != 0) ? 8'h02 : 8'h00};
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      end_of_test;
    end
  endtask

  task automatic op(input logic [7:0] o, input logic [31:0] s, input logic g, input logic [31:0] gv);
    @(posedge clk);
    issue_valid <= 1;
    issue_opcode <= o;
    issue_source <= s;
    issue_guard_present <= g;
    issue_guard <= gv;
  endtask

  task automatic idle(input int n);
    @(posedge clk);
    issue_valid <= 0;
    other_fp_flags <= 0;
    repeat (n) @(posedge clk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 0;
    tmo(n);
    chk(s_axi_bresp, r);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] r);
    int n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 0;
    tmo(n);
    chk(s_axi_rresp, r);
    chk(s_axi_rdata, rd_exp);
  endtask

  // ---------------------------------------------------------------
  // Reference model, compared at every edge
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      {v1, v2, ov, wr_pend, psw_m, ist_m, mask_m, last_m} = 0;
    end
    else
    begin
      chk(dest_write, ov);
      if (ov) chk(dest_data, od);
      chk(program_status_word, psw_m);
      chk(dest_value, last_m);
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_exp = (s_axi_araddr == `OFF_PSW) ? {24'h0, psw_m} : (s_axi_araddr == `OFF_DEST) ? (ov ? od : last_m) :
          (s_axi_araddr == `OFF_INT_STATUS) ? {30'h0, ist_m} : (s_axi_araddr == `OFF_INT_MASK) ? {30'h0, mask_m} : 0;
        if (s_axi_araddr == `OFF_INT_STATUS) ist_m = 0;
      end
      if (wr_pend && wa == `OFF_PSW) psw_m = wd[7:0] & `FLAG_MASK;
      if (wr_pend && wa == `OFF_INT_MASK) mask_m = wd[1:0];
      wr_pend = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
      wa = s_axi_awaddr;
      wd = s_axi_wdata;
      if (ov) last_m = od;
      ov = v2;
      od = c2 ? r2[39:8] : {24'h0, r2[7:0]};
      if (v2) ist_m[0] = 1;
      if (v2 && c2) psw_m |= r2[7:0];
      if (v2 && c2) ist_m[1] = ist_m[1] | r2[4];
      psw_m |= other_fp_flags & `FLAG_MASK;
      {v2, r2, c2} = {v1, r1, c1};
      v1 = issue_valid && (issue_opcode == `OPC_TRUNC || issue_opcode == `OPC_TRUNC_FLAGS)
        && (!issue_guard_present || issue_guard[0]);
      r1 = conv(issue_source);
      c1 = issue_opcode == `OPC_TRUNC;
    end
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 0;
    for (k = 0; k < 2; k++)
      for (i = 0; i < 12; i++)
        op(k ? `OPC_TRUNC_FLAGS : `OPC_TRUNC, vec[i], i[0], 32'h1);
    op(`OPC_TRUNC, 32'hff4fffff, 1, 32'h0);
    op(`OPC_TRUNC_FLAGS, 32'hff4fffff, 1, 32'h2);
    op(8'h7f, 32'h3f000000, 0, 32'h0);
    idle(6);
    axi_rd(`OFF_PSW, `RESP_OKAY);
    axi_wr(`OFF_INT_MASK, 32'h3, `RESP_OKAY);
    idle(3);
    chk(irq, |(ist_m & mask_m));
    axi_wr(`OFF_INT_MASK, 32'h0, `RESP_OKAY);
    idle(3);
    chk(irq, 0);
    axi_wr(`OFF_INT_MASK, 32'h3, `RESP_OKAY);
    axi_rd(`OFF_INT_STATUS, `RESP_OKAY);
    axi_rd(`OFF_INT_STATUS, `RESP_OKAY);
    idle(3);
    chk(irq, 0);
    axi_wr(`OFF_DEST, 32'h5a, `RESP_OKAY);
    axi_rd(`OFF_DEST, `RESP_OKAY);
    axi_wr(8'h14, 32'h1, `RESP_SLVERR);
    axi_rd(8'h14, `RESP_SLVERR);
    fork
      for (i = 0; i < 400; i++)
      begin
        seed = lfsr(seed);
        op(seed[1] ? (seed[0] ? 8'h7c : `OPC_TRUNC_FLAGS) : `OPC_TRUNC,
          seed[4] ? seed : {seed[31], 3'b100, seed[27:0]}, seed[2], seed);
        other_fp_flags <= (seed[11:8] == 0) ? seed[19:12] : 8'h0;
      end
      repeat (8)
      begin
        axi_wr(`OFF_PSW, 32'h0, `RESP_OKAY);
        axi_rd(`OFF_PSW, `RESP_OKAY);
        axi_rd(`OFF_INT_STATUS, `RESP_OKAY);
        repeat (20) @(posedge clk);
      end
    join
    idle(6);
    end_of_test;
  end
endmodule

bind float_to_uint_truncate_unit fixu_props props_u (.clk, .reset, .issue_valid, .issue_opcode,
  .issue_guard_present, .issue_guard, .other_fp_flags, .dest_write, .program_status_word,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

`default_nettype wire
